// ---- shared/topdb_pkg.sv ----
// Purpose: shared constants, types and decode helpers for the output protection block
// Assumes: four channel pairs, byte addresses on an 8-bit Wishbone address
// Notes: state types are packed so each module registers one struct

package topdb_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int CH_NUM = 4;
  localparam int DT_W = 11;
  localparam int IRQ_W = 3;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] ADR_CLK_CTL = 8'h00;
  localparam logic [7:0] ADR_IDLE_LVL = 8'h04;
  localparam logic [7:0] ADR_CH_MODE = 8'h18;
  localparam logic [7:0] ADR_CH_EN = 8'h20;
  localparam logic [7:0] ADR_WRITE_LOCK_LEVEL = 8'h44;
  localparam logic [7:0] ADR_DMA_CFG = 8'h48;
  localparam logic [7:0] ADR_BURST_BUF = 8'h4C;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h50;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h54;

  // ****************************************
  // field positions
  // ****************************************
  localparam int WRITE_LOCK_LEVEL_MAIN = 15;
  localparam int WRITE_LOCK_LEVEL_AUTO = 14;
  localparam int WRITE_LOCK_LEVEL_FPOL = 13;
  localparam int WRITE_LOCK_LEVEL_FEN = 12;
  localparam int WRITE_LOCK_LEVEL_RUN_OFF = 11;
  localparam int WRITE_LOCK_LEVEL_IDLE_OFF = 10;
  localparam int WRITE_LOCK_LEVEL_LOCK_LO = 8;
  localparam int WRITE_LOCK_LEVEL_DEAD_LO = 0;
  localparam int DMA_CNT_LO = 8;
  localparam int DMA_START_LO = 0;
  localparam int DIV_LO = 8;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_REEN = 1;
  localparam int IRQ_WRAP = 2;
  // per channel: mode [1:0], shadow enable [3], compare mode [6:4]
  localparam int CHM_STRIDE = 8;
  localparam logic [7:0] CHM_LOCK_MASK = 8'h78;
  // per channel: direct enable 0, direct pol 1, compl enable 2, compl pol 3
  localparam int CHE_STRIDE = 4;
  localparam int CHE_DEN = 0;
  localparam int CHE_DPOL = 1;
  localparam int CHE_CEN = 2;
  localparam int CHE_CPOL = 3;
  localparam logic [3:0] CHE_POL_MASK = 4'hA;
  // per channel: direct idle level 0, complement idle level 1
  localparam int IDL_STRIDE = 2;
  localparam logic [1:0] CH_MODE_OUT = 2'h0;
  localparam logic [3:0] SEL_WORD = 4'hF;
  localparam logic [1:0] SEL_HALF = 2'h3;

  // ****************************************
  // dead-time clock divider and decode
  // ****************************************
  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [2:0] DIV_LIM1 = 3'h0;
  localparam logic [2:0] DIV_LIM2 = 3'h1;
  localparam logic [2:0] DIV_LIM4 = 3'h3;
  localparam logic [DT_W-1:0] DT_BASE_64 = 11'h040;
  localparam logic [DT_W-1:0] DT_BASE_32 = 11'h020;

  typedef enum logic [1:0] {
    LOCK_OFF = 2'b00,
    LOCK_L1 = 2'b01,
    LOCK_L2 = 2'b10,
    LOCK_L3 = 2'b11
  } topdb_lock_e;

  typedef struct packed {
    logic [CH_NUM-1:0] direct;
    logic [CH_NUM-1:0] direct_oe;
    logic [CH_NUM-1:0] compl;
    logic [CH_NUM-1:0] compl_oe;
  } topdb_pins_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic main_en;
    logic auto_en;
    logic fault_pol;
    logic fault_en;
    logic run_off;
    logic idle_off;
    topdb_lock_e lock;
    logic lock_done;
    logic [7:0] dead_code;
    logic [4:0] burst_cnt;
    logic [4:0] burst_start;
    logic [4:0] burst_idx;
    logic [1:0] div_sel;
    logic [2:0] div_cnt;
    logic [IDL_STRIDE*CH_NUM-1:0] idle_lv;
    logic [CHE_STRIDE*CH_NUM-1:0] ch_en;
    logic [CHM_STRIDE*CH_NUM-1:0] ch_mode;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    topdb_pins_s pins;
  } topdb_state_s;

  typedef struct packed {
    logic ref_q;
    logic [DT_W-1:0] cnt;
    logic d_on;
    logic c_on;
  } topdb_dt_s;

  // dead-time code to tick count
  function automatic logic [DT_W-1:0] topdb_dead_ticks(input logic [7:0] code);
    if (!code[7]) begin
      return {3'h0, code};
    end else if (!code[6]) begin
      return (DT_BASE_64 + {5'h0, code[5:0]}) << 1;
    end else if (!code[5]) begin
      return (DT_BASE_32 + {6'h0, code[4:0]}) << 3;
    end else begin
      return (DT_BASE_32 + {6'h0, code[4:0]}) << 4;
    end
  endfunction : topdb_dead_ticks

endpackage : topdb_pkg

// ---- hw/topdb_dead_time.sv ----
// Purpose: dead-time insertion for one direct/complement channel pair
// Assumes: tick_i is a one-cycle enable at the dead-time tick rate
// Notes: both sides go inactive on every reference edge, then the new side waits

module topdb_dead_time (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // timing
  input wire logic tick_i,
  input wire logic [7:0] code_i,
  // reference and delayed outputs
  input wire logic ref_i,
  output logic direct_on_o,
  output logic compl_on_o
);

  topdb_pkg::topdb_dt_s st_reg;
  topdb_pkg::topdb_dt_s st_next;

  // ****************************************
  // delay on each rising side
  // ****************************************
  always_comb begin
    st_next = st_reg;
    if (ref_i != st_reg.ref_q) begin
      // break before make: neither side conducts during the count
      st_next.ref_q = ref_i;
      st_next.d_on = 1'b0;
      st_next.c_on = 1'b0;
      st_next.cnt = topdb_pkg::topdb_dead_ticks(code_i);
    end else if (st_reg.cnt != '0) begin
      if (tick_i) begin
        st_next.cnt = st_reg.cnt - 1'b1;
      end
    end else begin
      st_next.d_on = st_reg.ref_q;
      st_next.c_on = ~st_reg.ref_q;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign direct_on_o = st_reg.d_on;
  assign compl_on_o = st_reg.c_on;

endmodule : topdb_dead_time

// ---- hw/topdb_core.sv ----
// Purpose: complementary output protection, fault handling, write lock and burst addressing
// Assumes: inputs synchronous to clk_i; Wishbone classic slave, one wait state
// Notes: fault gating of the pin drive is combinational with the fault input; the registered pins follow one clock later

module topdb_core (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // timer events
  input wire logic update_evt_i,
  input wire logic fault_input_i,
  input wire logic clock_fail_detector_i,
  input wire logic [topdb_pkg::CH_NUM-1:0] pwm_ref_i,
  // channel pins and status
  output topdb_pkg::topdb_pins_s chan_o,
  output logic [4:0] burst_index_o,
  output logic irq_o
);

  topdb_pkg::topdb_state_s st_reg;
  topdb_pkg::topdb_state_s st_next;
  logic fault_now;
  logic eff_en;
  logic tick;
  logic req;
  logic wr;
  logic burst_acc;
  logic [5:0] tgt_idx;
  logic [7:0] eff_adr;
  logic [topdb_pkg::CH_NUM-1:0] dt_direct;
  logic [topdb_pkg::CH_NUM-1:0] dt_compl;
  // top bit of the event fields, declared ahead of the decode that slices with it
  localparam int IRQW_TOP = topdb_pkg::IRQ_W - 1;

  // ****************************************
  // register read mux
  // ****************************************
  function automatic logic [31:0] rd_word(input topdb_pkg::topdb_state_s s, input logic [7:0] a);
    if (a == topdb_pkg::ADR_CLK_CTL) begin
      return {22'h0, s.div_sel, 8'h0};
    end else if (a == topdb_pkg::ADR_IDLE_LVL) begin
      return {24'h0, s.idle_lv};
    end else if (a == topdb_pkg::ADR_CH_MODE) begin
      return s.ch_mode;
    end else if (a == topdb_pkg::ADR_CH_EN) begin
      return {16'h0, s.ch_en};
    end else if (a == topdb_pkg::ADR_WRITE_LOCK_LEVEL) begin
      return {16'h0, s.main_en, s.auto_en, s.fault_pol, s.fault_en,
              s.run_off, s.idle_off, s.lock, s.dead_code};
    end else if (a == topdb_pkg::ADR_DMA_CFG) begin
      return {19'h0, s.burst_cnt, 3'h0, s.burst_start};
    end else if (a == topdb_pkg::ADR_IRQ_STAT) begin
      return {29'h0, s.irq_stat};
    end else if (a == topdb_pkg::ADR_IRQ_MASK) begin
      return {29'h0, s.irq_mask};
    end else begin
      // unmapped, including the buffer aimed at itself
      return 32'h0000_0000;
    end
  endfunction : rd_word

  // ****************************************
  // fault detection and bus decode
  // ****************************************
  // polarity picks the active level; enable gates both sources
  assign fault_now = st_reg.fault_en & ((fault_input_i == st_reg.fault_pol) | clock_fail_detector_i);
  // fault removes enable at once, before the register catches up
  assign eff_en = st_reg.main_en & ~fault_now;
  assign req = cyc_i & stb_i;
  assign wr = req & we_i & st_reg.ack;
  assign burst_acc = req & st_reg.ack & (adr_i == topdb_pkg::ADR_BURST_BUF);
  // buffer accesses land on start plus index words
  assign tgt_idx = {1'b0, st_reg.burst_start} + {1'b0, st_reg.burst_idx};
  assign eff_adr = (adr_i == topdb_pkg::ADR_BURST_BUF) ? {tgt_idx, 2'b00} : adr_i;

  // dead-time tick divider
  always_comb begin
    if (st_reg.div_sel == topdb_pkg::DIV_BY1) begin
      tick = (st_reg.div_cnt == topdb_pkg::DIV_LIM1);
    end else if (st_reg.div_sel == topdb_pkg::DIV_BY2) begin
      tick = (st_reg.div_cnt >= topdb_pkg::DIV_LIM2);
    end else begin
      tick = (st_reg.div_cnt >= topdb_pkg::DIV_LIM4);
    end
  end

  // ****************************************
  // dead-time per channel pair
  // ****************************************
  for (genvar g = 0; g < topdb_pkg::CH_NUM; g++) begin : g_dt
    topdb_dead_time u_dt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .code_i(st_reg.dead_code),
      .ref_i(pwm_ref_i[g]),
      .direct_on_o(dt_direct[g]),
      .compl_on_o(dt_compl[g])
    );
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.ack = req & ~st_reg.ack;
    st_next.div_cnt = tick ? 3'h0 : st_reg.div_cnt + 3'h1;
    if (req & ~st_reg.ack) begin
      st_next.rdata = rd_word(st_reg, eff_adr);
    end

    // plain registers, whole word only
    if (wr && sel_i == topdb_pkg::SEL_WORD) begin
      if (eff_adr == topdb_pkg::ADR_CLK_CTL) begin
        st_next.div_sel = dat_i[topdb_pkg::DIV_LO +: 2];
      end else if (eff_adr == topdb_pkg::ADR_IDLE_LVL) begin
        if (st_reg.lock == topdb_pkg::LOCK_OFF) begin
          st_next.idle_lv = dat_i[topdb_pkg::IDL_STRIDE*topdb_pkg::CH_NUM-1:0];
        end
      end else if (eff_adr == topdb_pkg::ADR_CH_MODE) begin
        for (int c = 0; c < topdb_pkg::CH_NUM; c++) begin
          // compare mode and shadow enable freeze on output channels at level three
          if (st_reg.lock == topdb_pkg::LOCK_L3 &&
              st_reg.ch_mode[c*topdb_pkg::CHM_STRIDE +: 2] == topdb_pkg::CH_MODE_OUT) begin
            st_next.ch_mode[c*topdb_pkg::CHM_STRIDE +: topdb_pkg::CHM_STRIDE] =
              (dat_i[c*topdb_pkg::CHM_STRIDE +: topdb_pkg::CHM_STRIDE] & ~topdb_pkg::CHM_LOCK_MASK) |
              (st_reg.ch_mode[c*topdb_pkg::CHM_STRIDE +: topdb_pkg::CHM_STRIDE] & topdb_pkg::CHM_LOCK_MASK);
          end else begin
            st_next.ch_mode[c*topdb_pkg::CHM_STRIDE +: topdb_pkg::CHM_STRIDE] =
              dat_i[c*topdb_pkg::CHM_STRIDE +: topdb_pkg::CHM_STRIDE];
          end
        end
      end else if (eff_adr == topdb_pkg::ADR_CH_EN) begin
        for (int c = 0; c < topdb_pkg::CH_NUM; c++) begin
          // polarity of output channels freezes from level two up
          if (st_reg.lock[1] &&
              st_reg.ch_mode[c*topdb_pkg::CHM_STRIDE +: 2] == topdb_pkg::CH_MODE_OUT) begin
            st_next.ch_en[c*topdb_pkg::CHE_STRIDE +: topdb_pkg::CHE_STRIDE] =
              (dat_i[c*topdb_pkg::CHE_STRIDE +: topdb_pkg::CHE_STRIDE] & ~topdb_pkg::CHE_POL_MASK) |
              (st_reg.ch_en[c*topdb_pkg::CHE_STRIDE +: topdb_pkg::CHE_STRIDE] & topdb_pkg::CHE_POL_MASK);
          end else begin
            st_next.ch_en[c*topdb_pkg::CHE_STRIDE +: topdb_pkg::CHE_STRIDE] =
              dat_i[c*topdb_pkg::CHE_STRIDE +: topdb_pkg::CHE_STRIDE];
          end
        end
      end else if (eff_adr == topdb_pkg::ADR_DMA_CFG) begin
        // word-only; reprogramming restarts the burst
        st_next.burst_cnt = dat_i[topdb_pkg::DMA_CNT_LO +: 5];
        st_next.burst_start = dat_i[topdb_pkg::DMA_START_LO +: 5];
        st_next.burst_idx = 5'h0;
      end else if (eff_adr == topdb_pkg::ADR_IRQ_MASK) begin
        st_next.irq_mask = dat_i[IRQW_TOP:0];
      end else if (eff_adr == topdb_pkg::ADR_IRQ_STAT) begin
        st_next.irq_stat = st_reg.irq_stat & ~dat_i[IRQW_TOP:0];
      end
    end

    // protection register: half word or word
    if (wr && eff_adr == topdb_pkg::ADR_WRITE_LOCK_LEVEL && sel_i[1:0] == topdb_pkg::SEL_HALF) begin
      st_next.main_en = dat_i[topdb_pkg::WRITE_LOCK_LEVEL_MAIN];
      st_next.lock_done = 1'b1;
      if (!st_reg.lock_done) begin
        st_next.lock = topdb_pkg::topdb_lock_e'(dat_i[topdb_pkg::WRITE_LOCK_LEVEL_LOCK_LO +: 2]);
      end
      if (st_reg.lock == topdb_pkg::LOCK_OFF) begin
        st_next.auto_en = dat_i[topdb_pkg::WRITE_LOCK_LEVEL_AUTO];
        st_next.fault_pol = dat_i[topdb_pkg::WRITE_LOCK_LEVEL_FPOL];
        st_next.fault_en = dat_i[topdb_pkg::WRITE_LOCK_LEVEL_FEN];
        st_next.dead_code = dat_i[topdb_pkg::WRITE_LOCK_LEVEL_DEAD_LO +: 8];
      end
      if (!st_reg.lock[1]) begin
        st_next.run_off = dat_i[topdb_pkg::WRITE_LOCK_LEVEL_RUN_OFF];
        st_next.idle_off = dat_i[topdb_pkg::WRITE_LOCK_LEVEL_IDLE_OFF];
      end
    end else if (update_evt_i && st_reg.auto_en && !st_reg.main_en && !fault_now) begin
      st_next.main_en = 1'b1;
      st_next.irq_stat[topdb_pkg::IRQ_REEN] = 1'b1;
    end
    if (fault_now) begin
      st_next.main_en = 1'b0;
    end

    // burst index steps after each buffer access, wraps at count
    if (burst_acc) begin
      if (st_reg.burst_idx >= st_reg.burst_cnt) begin
        st_next.burst_idx = 5'h0;
        st_next.irq_stat[topdb_pkg::IRQ_WRAP] = 1'b1;
      end else begin
        st_next.burst_idx = st_reg.burst_idx + 5'h1;
      end
    end

    // events set after any clear so a coincident event is kept
    if (fault_now) begin
      st_next.irq_stat[topdb_pkg::IRQ_FAULT] = 1'b1;
    end

    // pin drive, registered
    for (int c = 0; c < topdb_pkg::CH_NUM; c++) begin
      st_next.pins.direct[c] = 1'b0;
      st_next.pins.direct_oe[c] = 1'b0;
      st_next.pins.compl[c] = 1'b0;
      st_next.pins.compl_oe[c] = 1'b0;
      if (st_reg.ch_mode[c*topdb_pkg::CHM_STRIDE +: 2] != topdb_pkg::CH_MODE_OUT) begin
        // not an output channel: pins stay released
        st_next.pins.direct_oe[c] = 1'b0;
      end else if (eff_en) begin
        if (st_reg.ch_en[c*topdb_pkg::CHE_STRIDE + topdb_pkg::CHE_DEN]) begin
          st_next.pins.direct[c] = dt_direct[c] ^ st_reg.ch_en[c*topdb_pkg::CHE_STRIDE + topdb_pkg::CHE_DPOL];
          st_next.pins.direct_oe[c] = 1'b1;
        end else if (st_reg.run_off) begin
          st_next.pins.direct[c] = st_reg.ch_en[c*topdb_pkg::CHE_STRIDE + topdb_pkg::CHE_DPOL];
          st_next.pins.direct_oe[c] = 1'b1;
        end
        if (st_reg.ch_en[c*topdb_pkg::CHE_STRIDE + topdb_pkg::CHE_CEN]) begin
          st_next.pins.compl[c] = dt_compl[c] ^ st_reg.ch_en[c*topdb_pkg::CHE_STRIDE + topdb_pkg::CHE_CPOL];
          st_next.pins.compl_oe[c] = 1'b1;
        end else if (st_reg.run_off) begin
          st_next.pins.compl[c] = st_reg.ch_en[c*topdb_pkg::CHE_STRIDE + topdb_pkg::CHE_CPOL];
          st_next.pins.compl_oe[c] = 1'b1;
        end
      end else if (st_reg.idle_off) begin
        // idle: forced to the idle levels whatever the enables
        st_next.pins.direct[c] = st_reg.idle_lv[c*topdb_pkg::IDL_STRIDE];
        st_next.pins.compl[c] = st_reg.idle_lv[c*topdb_pkg::IDL_STRIDE + 1];
        st_next.pins.direct_oe[c] = 1'b1;
        st_next.pins.compl_oe[c] = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign dat_o = st_reg.rdata;
  assign ack_o = st_reg.ack;
  assign chan_o = st_reg.pins;
  assign burst_index_o = st_reg.burst_idx;
  // level interrupt while any unmasked status bit stands
  assign irq_o = |(st_reg.irq_stat & st_reg.irq_mask);

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_fault_clears;
    fault_now |=> !st_reg.main_en;
  endproperty
  a_fault_clears: assert property (p_fault_clears) else $error("main enable survived a fault");

  property p_auto_sets;
    (update_evt_i && st_reg.auto_en && !st_reg.main_en && !fault_now && !wr) |=> st_reg.main_en;
  endproperty
  a_auto_sets: assert property (p_auto_sets) else $error("auto reenable missed update");

  property p_no_auto;
    (!st_reg.auto_en && !st_reg.main_en && !wr) |=> !st_reg.main_en;
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("main enable set without software");

  property p_lock_once;
    st_reg.lock_done |=> $stable(st_reg.lock);
  endproperty
  a_lock_once: assert property (p_lock_once) else $error("lock level changed twice");

  property p_lock1_frozen;
    (st_reg.lock != topdb_pkg::LOCK_OFF) |=> $stable(st_reg.dead_code) && $stable(st_reg.fault_en)
      && $stable(st_reg.auto_en) && $stable(st_reg.idle_lv);
  endproperty
  a_lock1_frozen: assert property (p_lock1_frozen) else $error("level one field was written");

  property p_lock2_frozen;
    st_reg.lock[1] |=> $stable(st_reg.run_off) && $stable(st_reg.idle_off);
  endproperty
  a_lock2_frozen: assert property (p_lock2_frozen) else $error("off-state bit written under lock");

  property p_lock3_frozen;
    (st_reg.lock == topdb_pkg::LOCK_L3 && st_reg.ch_mode[1:0] == topdb_pkg::CH_MODE_OUT)
      |=> (st_reg.ch_mode[6:3] == $past(st_reg.ch_mode[6:3]));
  endproperty
  a_lock3_frozen: assert property (p_lock3_frozen) else $error("compare mode written under lock");

  property p_idle_release;
    (!eff_en && !st_reg.idle_off) |=> (st_reg.pins.direct_oe == '0) && (st_reg.pins.compl_oe == '0);
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("pins driven in idle");

  property p_burst_wrap;
    (burst_acc && st_reg.burst_idx >= st_reg.burst_cnt) |=> (st_reg.burst_idx == 5'h0) ##1 !ack_o;
  endproperty
  a_burst_wrap: assert property (p_burst_wrap) else $error("burst index did not wrap");

  property p_ack_pulse;
    (req && !ack_o) |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a one-cycle answer");

  c_auto: cover property (update_evt_i && st_reg.auto_en && !st_reg.main_en ##1 st_reg.main_en);
  c_wrap: cover property (burst_acc && st_reg.burst_cnt != 5'h0 && st_reg.burst_idx == st_reg.burst_cnt);
  c_lock: cover property (st_reg.lock == topdb_pkg::LOCK_L3 && st_reg.lock_done);
  c_fault: cover property (st_reg.main_en && fault_now);

endmodule : topdb_core

// ---- bench/topdb_gate_model.sv ----
// Purpose: gate driver model on channel pair 0, watches for shoot-through
// Assumes: polarity bits left at 0, so a driven high pin means conducting
// Notes: the stage drives nothing back; it only counts what it sees

module topdb_gate_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pins from the block
  input wire topdb_pkg::topdb_pins_s pins_i,
  // observations
  output int overlap_o,
  output int min_gap_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic d_act;
  logic c_act;
  int gap;
  // a side conducts only while driven and high
  assign d_act = pins_i.direct[0] & pins_i.direct_oe[0];
  assign c_act = pins_i.compl[0] & pins_i.compl_oe[0];
  // both on at once would short the half bridge
  always @(posedge clk_i) begin
    if (rst_i) begin
      overlap_o <= 0;
      min_gap_o <= 255;
      gap <= 0;
    end else begin
      if (d_act && c_act) overlap_o <= overlap_o + 1;
      gap <= (d_act || c_act) ? 0 : gap + 1;
      if ((d_act || c_act) && gap > 0 && gap < min_gap_o) min_gap_o <= gap;
    end
  end
endmodule : topdb_gate_model

// ---- bench/topdb_core_tb.sv ----
// Purpose: self-checking bench for the output protection core
// Assumes: one wait state slave, reads checked by a monitor from a queue
// Notes: a second reset reopens the write-once lock field
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end

module topdb_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, upd = 0, flt = 1, cfail = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0, pwm = 4'h0, tcnt = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, exp_v;
  logic ack_o, irq_o;
  logic [4:0] bidx;
  topdb_pkg::topdb_pins_s chan;
  int bad_count = 0, comparisons = 0, seed = 38300, ovl, gap;
  logic [31:0] expq[$];
  topdb_core topdb_core_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .update_evt_i(upd),
    .fault_input_i(flt), .clock_fail_detector_i(cfail), .pwm_ref_i(pwm), .chan_o(chan),
    .burst_index_o(bidx), .irq_o(irq_o));
  topdb_gate_model topdb_gate_model_i (.clk_i(clk_i), .rst_i(rst_i), .pins_i(chan),
    .overlap_o(ovl), .min_gap_o(gap));
  always #2.5 clk_i = ~clk_i;
  // reference changes every 16 cycles so each side gets room to turn on
  always @(posedge clk_i) begin
    tcnt <= tcnt + 4'h1;
    if (tcnt == 4'h0) pwm <= 4'($random(seed));
  end
  // read results are judged against the oldest note at the edge that sees ack high
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && expq.size() > 0) begin
      exp_v = expq.pop_front();
      `CHK(dat_o, exp_v)
    end
  end
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // one classic cycle, held until ack is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d, input logic [31:0] e);
    int n;
    n = 0;
    if (!w) expq.push_back(e);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; sel_i <= s; dat_i <= d;
    // ack is looked at on rising edges only, before the design moves it
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) begin
      bad_count++;
      print_verdict();
    end
    cyc_i <= 1'b0; stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, 4'hF, d, 32'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 4'hF, 32'h0, e);
  endtask : rd
  task automatic pulse_reset();
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : pulse_reset
  task automatic pulse_update();
    upd <= 1'b1;
    @(posedge clk_i);
    upd <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : pulse_update
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    pulse_reset();
    rd(8'h44, 32'h0);
    rd(8'h48, 32'h0);
    wr(8'h54, 32'h1);
    wr(8'h44, 32'h8000);
    flt <= 1'b0;
    rd(8'h44, 32'h8000);
    wr(8'h44, 32'hB000);
    rd(8'h44, 32'hB000);
    flt <= 1'b1;
    // let the fault clear the enable before the read data is latched
    @(posedge clk_i);
    rd(8'h44, 32'h3000);
    `CHK(irq_o, 1'b1)
    flt <= 1'b0;
    wr(8'h50, 32'h7);
    `CHK(irq_o, 1'b0)
    wr(8'h44, 32'hB000);
    cfail <= 1'b1;
    @(posedge clk_i);
    rd(8'h44, 32'h3000);
    cfail <= 1'b0;
    pulse_reset();
    flt <= 1'b1;
    wr(8'h20, 32'h5555);
    bus(1'b1, 8'h44, 4'h3, 32'h5105, 32'h0);
    rd(8'h44, 32'h5105);
    pulse_update();
    rd(8'h44, 32'hD105);
    `CHK(chan.direct_oe, 4'hF)
    repeat (200) @(posedge clk_i);
    wr(8'h44, 32'h0);
    rd(8'h44, 32'h5105);
    `CHK(chan.direct_oe, 4'h0)
    wr(8'h44, 32'h8300);
    rd(8'h44, 32'hD105);
    flt <= 1'b0;
    repeat (3) @(posedge clk_i);
    pulse_update();
    rd(8'h44, 32'h5105);
    flt <= 1'b1;
    bus(1'b1, 8'h48, 4'h3, 32'h0111, 32'h0);
    rd(8'h48, 32'h0);
    wr(8'h48, 32'h0111);
    rd(8'h4C, 32'h5105);
    rd(8'h4C, 32'h0111);
    `CHK(bidx, 5'h00)
    rd(8'h48, 32'h0111);
    wr(8'hF0, $random(seed));
    rd(8'hF0, 32'h0);
    `CHK(ovl, 0)
    `CHK(gap >= 5 && gap < 40, 1'b1)
    // full lock with both off-states, channel 1 an input
    pulse_reset();
    wr(8'h00, 32'h0100);
    wr(8'h04, 32'h00AA);
    wr(8'h18, 32'h0000_0178);
    wr(8'h20, 32'h0000_0002);
    wr(8'h44, 32'h8F00);
    rd(8'h44, 32'h8F00);
    `CHK(chan.direct_oe, 4'hD)
    `CHK(chan.direct, 4'h1)
    wr(8'h44, 32'h0000);
    rd(8'h44, 32'h0F00);
    `CHK(chan.compl, 4'hD)
    `CHK(chan.compl_oe, 4'hD)
    wr(8'h20, 32'h0000_0000);
    rd(8'h20, 32'h0000_0002);
    wr(8'h18, 32'h0000_0000);
    rd(8'h18, 32'h0000_0078);
    wr(8'h04, 32'h0000_0000);
    rd(8'h04, 32'h0000_00AA);
    rd(8'h00, 32'h0000_0100);
    print_verdict();
  end
endmodule : topdb_core_tb
